// File: t1lps_regs.sv
// sublayer status and control register bank behind an APB slave
//
// Design decision made here: register access over APB.
`include "t1lps_consts.svh"

module t1lps_regs (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire t1lps_pkg::t1lps_live_t live_i,
  input wire logic [15:0] mse_i,
  output t1lps_pkg::t1lps_ctrl_t ctrl_o,
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  // bus side
  logic [20:0] key_c;
  logic mapped_c;
  logic writable_c;
  logic [15:0] rdata_c;
  logic setup_c;
  logic access_c;
  logic wr_c;
  logic rd_c;
  logic [15:0] wmask_c;
  logic [15:0] wval_c;

  // register hits
  logic hit_ctrl_c;
  logic hit_gain_c;
  logic hit_link_c;
  logic hit_clr_c;
  logic hit_en_c;

  // soft reset handshake
  logic srst_start_c;
  logic srst_done_c;

  // stored state
  logic [31:0] prdata_q;
  logic [15:0] gain_q;
  logic loop_q;
  logic pd_q;
  t1lps_pkg::t1lps_srst_t srst_q;
  logic [7:0] srst_cnt_q;
  logic [15:0] mse_q;

  // health flags
  logic [`T1LPS_NFLAG-1:0] live_c;
  logic [`T1LPS_NFLAG-1:0] live_prev_q;
  logic [`T1LPS_NFLAG-1:0] ll_q;
  logic [`T1LPS_NFLAG-1:0] ll_c;
  logic [`T1LPS_NFLAG-1:0] drop_c;

  // interrupts and link word
  logic [`T1LPS_NIRQ-1:0] irq_stat_q;
  logic [`T1LPS_NIRQ-1:0] irq_en_q;
  logic [`T1LPS_NIRQ-1:0] irq_evt_c;
  logic [`T1LPS_NIRQ-1:0] irq_clr_c;
  logic [15:0] link_word_c;

  // --------------------------------------------------------------------------
  // bus phase decode
  // --------------------------------------------------------------------------
  assign setup_c = psel_i & ~penable_i;
  assign access_c = psel_i & penable_i;
  // zero wait states: every access completes in its first access cycle
  assign pready_o = access_c;
  // unmapped or misaligned words answer with an error and no side effect
  assign pslverr_o = access_c & ~mapped_c;
  assign wr_c = access_c & pwrite_i & mapped_c & writable_c;
  assign rd_c = access_c & ~pwrite_i & mapped_c;
  assign key_c = paddr_i[22:2];
  // only the low half-word carries register data, upper strobes are ignored
  assign wmask_c = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign wval_c = pwdata_i[15:0];

  always_comb begin
    mapped_c = 1'b0;
    // upper address bits and byte offset must be zero
    if (paddr_i[31:23] == 9'h000 && paddr_i[1:0] == 2'b00) begin
      unique case (key_c)
        {`T1LPS_DEV_PMA, `T1LPS_REG_CTRL1},
        {`T1LPS_DEV_PCS, `T1LPS_REG_CTRL1},
        {`T1LPS_DEV_PCS, `T1LPS_REG_STAT1},
        {`T1LPS_DEV_PCS, `T1LPS_REG_PKG1},
        {`T1LPS_DEV_PCS, `T1LPS_REG_PKG2},
        {`T1LPS_DEV_PCS, `T1LPS_REG_STAT2},
        {`T1LPS_DEV_PMA, `T1LPS_REG_GAIN},
        {`T1LPS_DEV_PMA, `T1LPS_REG_LINK},
        {`T1LPS_DEV_PMA, `T1LPS_REG_MSE},
        {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_STAT},
        {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_CLR},
        {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_EN}: begin
          mapped_c = 1'b1;
        end
        default: begin
          mapped_c = 1'b0;
        end
      endcase
    end
  end

  // both control locations decode to one store
  assign hit_ctrl_c = key_c == {`T1LPS_DEV_PMA, `T1LPS_REG_CTRL1}
                   || key_c == {`T1LPS_DEV_PCS, `T1LPS_REG_CTRL1};
  assign hit_gain_c = key_c == {`T1LPS_DEV_PMA, `T1LPS_REG_GAIN};
  assign hit_link_c = key_c == {`T1LPS_DEV_PMA, `T1LPS_REG_LINK};
  assign hit_clr_c = key_c == {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_CLR};
  assign hit_en_c = key_c == {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_EN};
  // writes to read-only words complete without error and change nothing
  assign writable_c = hit_ctrl_c | hit_gain_c | hit_clr_c | hit_en_c;

  // --------------------------------------------------------------------------
  // latched-low health flags
  // --------------------------------------------------------------------------
  assign live_c = live_i;

  genvar gi;
  generate
    for (gi = 0; gi < `T1LPS_NFLAG; gi = gi + 1) begin : g_flag
      // a drop in the reading cycle is still seen: live low wins over release
      assign ll_c[gi] = ll_q[gi] & live_c[gi];
      // a one-cycle dip is enough to raise the matching event
      assign drop_c[gi] = live_prev_q[gi] & ~live_c[gi];

      // a condition that is down while read stays latched low
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          ll_q[gi] <= 1'b0;
        end else if (rd_c && hit_link_c) begin
          ll_q[gi] <= live_c[gi];
        end else begin
          ll_q[gi] <= ll_c[gi];
        end
      end
    end
  endgenerate

  // reset low so a port that comes up down is not seen as a drop
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      live_prev_q <= '0;
    end else begin
      live_prev_q <= live_c;
    end
  end

  // each live bit sits one below its latched copy
  always_comb begin
    link_word_c = 16'h0000;
    link_word_c[0] = live_i.link_ok;
    link_word_c[1] = ll_c[0];
    link_word_c[4] = live_i.unscrambler_ok;
    link_word_c[5] = ll_c[1];
    link_word_c[6] = live_i.near_receiver_ok;
    link_word_c[7] = ll_c[2];
    link_word_c[8] = live_i.far_receiver_ok;
    link_word_c[9] = ll_c[3];
  end

  // --------------------------------------------------------------------------
  // line quality readout
  // --------------------------------------------------------------------------
  // sampled every cycle so the read word is a clean flop value
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      mse_q <= 16'h0000;
    end else begin
      mse_q <= mse_i;
    end
  end

  // --------------------------------------------------------------------------
  // soft reset sequencer
  // --------------------------------------------------------------------------
  // a start while busy is refused so the reset cannot be stretched
  assign srst_start_c = wr_c & hit_ctrl_c & pstrb_i[1]
                      & wval_c[`T1LPS_BIT_SRST] & (srst_q == t1lps_pkg::T1LPS_SR_IDLE);
  // busy lasts exactly the programmed count of cycles
  assign srst_done_c = (srst_q == t1lps_pkg::T1LPS_SR_BUSY) && (srst_cnt_q == 8'h01);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      srst_q <= t1lps_pkg::T1LPS_SR_IDLE;
      srst_cnt_q <= 8'h00;
    end else begin
      unique case (srst_q)
        t1lps_pkg::T1LPS_SR_IDLE: begin
          if (srst_start_c) begin
            srst_q <= t1lps_pkg::T1LPS_SR_BUSY;
            srst_cnt_q <= 8'(`T1LPS_SRST_CYC);
          end
        end
        t1lps_pkg::T1LPS_SR_BUSY: begin
          srst_cnt_q <= srst_cnt_q - 8'h01;
          if (srst_done_c) begin
            srst_q <= t1lps_pkg::T1LPS_SR_IDLE;
          end
        end
        default: begin
          srst_q <= t1lps_pkg::T1LPS_SR_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // control store
  // --------------------------------------------------------------------------
  // a soft reset returns the controls to their reset values and holds them
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      loop_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (srst_start_c || srst_q == t1lps_pkg::T1LPS_SR_BUSY) begin
      loop_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (wr_c && hit_ctrl_c && pstrb_i[1]) begin
      pd_q <= wval_c[`T1LPS_BIT_PD];
      // loopback exists only in the coding sublayer word
      if (key_c[20:16] == `T1LPS_DEV_PCS) begin
        loop_q <= wval_c[`T1LPS_BIT_LOOP];
      end
    end
  end

  // byte strobes let software update half of the gain at a time
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      gain_q <= `T1LPS_GAIN_RST;
    end else if (srst_start_c || srst_q == t1lps_pkg::T1LPS_SR_BUSY) begin
      gain_q <= `T1LPS_GAIN_RST;
    end else if (wr_c && hit_gain_c) begin
      gain_q <= (gain_q & ~wmask_c) | (wval_c & wmask_c);
    end
  end

  // the reset level is a decode of the one-hot busy flop, so it is glitch free
  assign ctrl_o.coding_sublayer_soft_reset = (srst_q == t1lps_pkg::T1LPS_SR_BUSY);
  assign ctrl_o.coding_sublayer_loopback = loop_q;
  assign ctrl_o.coding_sublayer_power_down = pd_q;
  assign ctrl_o.echo_acq_recovery_gain = gain_q;

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  // bits 3:0 flag a drop of each health condition, bit 4 a finished soft reset
  assign irq_evt_c = {srst_done_c, drop_c};
  // clear ignores strobes: any written one clears its status bit
  assign irq_clr_c = (wr_c && hit_clr_c) ? wval_c[`T1LPS_NIRQ-1:0] : '0;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_stat_q <= '0;
    end else begin
      // an event in the clearing cycle survives the clear
      irq_stat_q <= (irq_stat_q & ~irq_clr_c) | irq_evt_c;
    end
  end

  // enables live in the low byte, so they need strobe 0
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      irq_en_q <= '0;
    end else if (wr_c && hit_en_c && pstrb_i[0]) begin
      irq_en_q <= wval_c[`T1LPS_NIRQ-1:0];
    end
  end

  // level output: high until software clears or masks the source
  assign irq_o = |(irq_stat_q & irq_en_q);

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  // the write-only clear word and unmapped keys read as zero
  always_comb begin
    rdata_c = 16'h0000;
    unique case (key_c)
      {`T1LPS_DEV_PMA, `T1LPS_REG_CTRL1},
      {`T1LPS_DEV_PCS, `T1LPS_REG_CTRL1}: begin
        rdata_c[`T1LPS_BIT_SRST] = (srst_q == t1lps_pkg::T1LPS_SR_BUSY);
        rdata_c[`T1LPS_BIT_PD] = pd_q;
        if (key_c[20:16] == `T1LPS_DEV_PCS) begin
          rdata_c[`T1LPS_BIT_LOOP] = loop_q;
        end
      end
      {`T1LPS_DEV_PCS, `T1LPS_REG_STAT1}: begin
        rdata_c = `T1LPS_STAT1_VAL;
      end
      {`T1LPS_DEV_PCS, `T1LPS_REG_PKG1}: begin
        rdata_c = `T1LPS_PKG1_VAL;
      end
      {`T1LPS_DEV_PCS, `T1LPS_REG_PKG2}: begin
        rdata_c = `T1LPS_PKG2_VAL;
      end
      {`T1LPS_DEV_PCS, `T1LPS_REG_STAT2}: begin
        rdata_c = `T1LPS_STAT2_VAL;
      end
      {`T1LPS_DEV_PMA, `T1LPS_REG_GAIN}: begin
        rdata_c = gain_q;
      end
      {`T1LPS_DEV_PMA, `T1LPS_REG_LINK}: begin
        rdata_c = link_word_c;
      end
      {`T1LPS_DEV_PMA, `T1LPS_REG_MSE}: begin
        rdata_c = mse_q;
      end
      {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_STAT}: begin
        rdata_c[`T1LPS_NIRQ-1:0] = irq_stat_q;
      end
      {`T1LPS_DEV_VND, `T1LPS_REG_IRQ_EN}: begin
        rdata_c[`T1LPS_NIRQ-1:0] = irq_en_q;
      end
      default: begin
        rdata_c = 16'h0000;
      end
    endcase
  end

  // read data is captured at the setup edge so it is a flop in the access cycle
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_c) begin
      prdata_q <= (mapped_c && !pwrite_i) ? {16'h0000, rdata_c} : 32'h0000_0000;
    end
  end

  assign prdata_o = prdata_q;

endmodule

// File: t1lps_consts.svh
// constants for the sublayer status and control register bank
`ifndef T1LPS_CONSTS_SVH
`define T1LPS_CONSTS_SVH
// ----------------------------------------------------------------------------
// address map: byte address = 4 * {device, register}
// ----------------------------------------------------------------------------
`define T1LPS_DEV_PMA 5'h01
`define T1LPS_DEV_PCS 5'h03
`define T1LPS_DEV_VND 5'h1F
`define T1LPS_REG_CTRL1 16'h0000
`define T1LPS_REG_STAT1 16'h0001
`define T1LPS_REG_PKG1 16'h0005
`define T1LPS_REG_PKG2 16'h0006
`define T1LPS_REG_STAT2 16'h0008
`define T1LPS_REG_GAIN 16'h81E7
`define T1LPS_REG_LINK 16'h8302
`define T1LPS_REG_MSE 16'h830B
`define T1LPS_REG_IRQ_STAT 16'h0010
`define T1LPS_REG_IRQ_CLR 16'h0011
`define T1LPS_REG_IRQ_EN 16'h0012
// ----------------------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------------------
`define T1LPS_BIT_SRST 15
`define T1LPS_BIT_LOOP 14
`define T1LPS_BIT_PD 11
`define T1LPS_GAIN_RST 16'h0400
`define T1LPS_STAT1_VAL 16'h0002
`define T1LPS_PKG1_VAL 16'h008B
`define T1LPS_PKG2_VAL 16'hC000
`define T1LPS_STAT2_VAL 16'h8000
`define T1LPS_NFLAG 4
`define T1LPS_NIRQ 5
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define T1LPS_CLK_NS 10
`define T1LPS_SRST_NS 100
`define T1LPS_SRST_CYC ((`T1LPS_SRST_NS + `T1LPS_CLK_NS - 1) / `T1LPS_CLK_NS)
`endif

// File: t1lps_pkg.sv
// types shared by the sublayer status and control register bank
package t1lps_pkg;
  // live health inputs, flag order matches the latch vector [3:0]
  typedef struct packed {
    logic far_receiver_ok;
    logic near_receiver_ok;
    logic unscrambler_ok;
    logic link_ok;
  } t1lps_live_t;

  typedef struct packed {
    logic coding_sublayer_soft_reset;
    logic coding_sublayer_loopback;
    logic coding_sublayer_power_down;
    logic [15:0] echo_acq_recovery_gain;
  } t1lps_ctrl_t;

  typedef enum logic [1:0] {
    T1LPS_SR_IDLE = 2'b01,
    T1LPS_SR_BUSY = 2'b10
  } t1lps_srst_t;
endpackage

// File: t1lps_regs_monitor.sv
// concurrent checks on the ports of the sublayer register bank
`include "t1lps_consts.svh"

module t1lps_regs_monitor (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire t1lps_pkg::t1lps_live_t live_i,
  input wire logic [15:0] mse_i,
  input wire t1lps_pkg::t1lps_ctrl_t ctrl_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [31:0] ad(input logic [4:0] d, input logic [15:0] r);
    return {9'h000, d, r, 2'b00};
  endfunction
  logic acc;
  logic rd;
  logic sr;
  logic ctl_w;
  assign acc = psel_i && penable_i;
  assign rd = acc && !pwrite_i;
  assign sr = ctrl_o.coding_sublayer_soft_reset;
  // either control word may start the reset
  assign ctl_w = acc && pwrite_i && pstrb_i[1] && pwdata_i[15] &&
    (paddr_i == ad(`T1LPS_DEV_PCS, `T1LPS_REG_CTRL1) || paddr_i == ad(`T1LPS_DEV_PMA, `T1LPS_REG_CTRL1));
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_reset_vals: assert property ($rose(rstn_i) |-> ctrl_o == 19'h00400)
    else $error("control outputs not at reset values");
  a_srst_start: assert property (ctl_w && !sr |=> sr)
    else $error("soft reset did not start");
  a_srst_len: assert property ($rose(sr) |-> ##9 sr ##1 !sr)
    else $error("soft reset length wrong");
  a_gain_write: assert property (acc && pwrite_i && pstrb_i == 4'hF && !sr &&
    paddr_i == ad(`T1LPS_DEV_PMA, `T1LPS_REG_GAIN) |=> ctrl_o.echo_acq_recovery_gain == $past(pwdata_i[15:0]))
    else $error("gain write lost");
  a_stat_one: assert property (rd && paddr_i == ad(`T1LPS_DEV_PCS, `T1LPS_REG_STAT1) |-> prdata_o == 32'h0000_0002)
    else $error("status one word wrong");
  a_presence_words: assert property (rd && paddr_i == ad(`T1LPS_DEV_PCS, `T1LPS_REG_PKG1) |-> prdata_o == 32'h0000_008B)
    else $error("first presence word wrong");
  a_presence_hi: assert property (rd && paddr_i == ad(`T1LPS_DEV_PCS, `T1LPS_REG_PKG2) |->
    prdata_o == 32'h0000_C000)
    else $error("second presence word wrong");
  a_stat_two: assert property (rd && paddr_i == ad(`T1LPS_DEV_PCS, `T1LPS_REG_STAT2) |-> prdata_o[15:14] == 2'h2)
    else $error("status two field wrong");
  a_link_zero: assert property (rd && paddr_i == ad(`T1LPS_DEV_PMA, `T1LPS_REG_LINK) |->
    prdata_o[31:10] == 22'h0 && prdata_o[3:2] == 2'h0)
    else $error("link word reserved bits set");
  a_link_live: assert property (rd && paddr_i == ad(`T1LPS_DEV_PMA, `T1LPS_REG_LINK) |->
    {prdata_o[8], prdata_o[6], prdata_o[4], prdata_o[0]} == $past(live_i))
    else $error("live health bits wrong");
  a_latch_below: assert property (rd && paddr_i == ad(`T1LPS_DEV_PMA, `T1LPS_REG_LINK) |->
    (prdata_o[9:0] & ~{prdata_o[8:0], 1'b0} & 10'h2A2) == 10'h0)
    else $error("latched bit set while live bit clear");
  a_mse_read: assert property (rd && paddr_i == ad(`T1LPS_DEV_PMA, `T1LPS_REG_MSE) |->
    prdata_o == {16'h0000, $past(mse_i, 2)})
    else $error("mean square error readout wrong");
endmodule

bind t1lps_regs t1lps_regs_monitor t1lps_regs_monitor_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .live_i(live_i), .mse_i(mse_i),
  .ctrl_o(ctrl_o), .irq_o(irq_o));

// File: t1l_pma_pcs_status_regs_tb_top.sv
// self-checking bench for the sublayer register bank over APB
`include "t1lps_consts.svh"

module t1l_pma_pcs_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rdat;
  logic [3:0] pstrb_i = 4'h0;
  logic pready_o, pslverr_o, irq_o, rerr;
  t1lps_pkg::t1lps_live_t live_i = 4'hF;
  logic [15:0] mse_i = 16'h2468;
  t1lps_pkg::t1lps_ctrl_t ctrl_o;
  int failures = 0;
  int check_count = 0;
  int n;
  // latched copies of link, unscrambler, near, far
  logic [15:0] lat [4] = '{16'h0002, 16'h0020, 16'h0080, 16'h0200};
  t1lps_regs t1lps_regs_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .live_i(live_i), .mse_i(mse_i), .ctrl_o(ctrl_o), .irq_o(irq_o));
  always #5 mclk_i = ~mclk_i;
  function automatic logic [31:0] ad(input logic [4:0] d, input logic [15:0] r);
    return {9'h000, d, r, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d, input logic [3:0] s);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {16'h0000, d};
    pstrb_i <= s;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // pready_o high ends this wait; only the watchdog bounds it
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000, 4'h0);
    chk(rdat, {16'h0000, e});
    chk({31'h0, rerr}, 32'h0);
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(ad(5'h03, 16'h0001), 16'h0002);
    rd(ad(5'h03, 16'h0005), 16'h008B);
    rd(ad(5'h03, 16'h0006), 16'hC000);
    rd(ad(5'h03, 16'h0008), 16'h8000);
    rd(ad(5'h01, 16'h81E7), 16'h0400);
    rd(ad(5'h03, 16'h0000), 16'h0000);
    rd(ad(5'h01, 16'h8302), 16'h0151);
    rd(ad(5'h01, 16'h8302), 16'h03F3);
    wr(ad(5'h03, 16'h0001), 16'hFFFF);
    rd(ad(5'h03, 16'h0001), 16'h0002);
    wr(ad(5'h1F, 16'h0012), 16'h001F);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      live_i <= 4'hF ^ (4'h1 << i);
      @(posedge mclk_i);
      live_i <= 4'hF;
      tick();
      tick();
      chk({31'h0, irq_o}, 32'h1);
      rd(ad(5'h01, 16'h8302), 16'h03F3 ^ lat[i]);
      rd(ad(5'h01, 16'h8302), 16'h03F3);
      rd(ad(5'h1F, 16'h0010), 16'h0001 << i);
      wr(ad(5'h1F, 16'h0011), 16'h001F);
      tick();
      chk({31'h0, irq_o}, 32'h0);
    end
    // masked event still lands in status but keeps the line low
    wr(ad(5'h1F, 16'h0012), 16'h0000);
    @(posedge mclk_i);
    live_i <= 4'hE;
    tick();
    chk({31'h0, irq_o}, 32'h0);
    rd(ad(5'h01, 16'h8302), 16'h03F0);
    live_i <= 4'hF;
    rd(ad(5'h1F, 16'h0010), 16'h0001);
    wr(ad(5'h1F, 16'h0011), 16'h001F);
    rd(ad(5'h01, 16'h8302), 16'h03F1);
    wr(ad(5'h01, 16'h81E7), 16'hABCD);
    tick();
    chk({16'h0, ctrl_o.echo_acq_recovery_gain}, 32'h0000_ABCD);
    apb(1'b1, ad(5'h01, 16'h81E7), 16'h5511, 4'h1);
    rd(ad(5'h01, 16'h81E7), 16'hAB11);
    wr(ad(5'h03, 16'h0000), 16'h4800);
    rd(ad(5'h03, 16'h0000), 16'h4800);
    rd(ad(5'h01, 16'h0000), 16'h0800);
    chk({29'h0, ctrl_o[18:16]}, 32'h3);
    wr(ad(5'h01, 16'h0000), 16'h0000);
    rd(ad(5'h03, 16'h0000), 16'h4000);
    rd(ad(5'h01, 16'h830B), 16'h2468);
    wr(ad(5'h01, 16'h830B), 16'h0000);
    rd(ad(5'h01, 16'h830B), 16'h2468);
    wr(ad(5'h03, 16'h0000), 16'h8000);
    rd(ad(5'h01, 16'h0000), 16'h8000);
    n = 0;
    while (ctrl_o.coding_sublayer_soft_reset !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    chk({31'h0, ctrl_o.coding_sublayer_soft_reset}, 32'h0);
    rd(ad(5'h03, 16'h0000), 16'h0000);
    rd(ad(5'h01, 16'h81E7), 16'h0400);
    rd(ad(5'h1F, 16'h0010), 16'h0010);
    apb(1'b0, 32'h0000_1000, 16'h0000, 4'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, ad(5'h03, 16'h0001) | 32'h2, 16'h0000, 4'h0);
    chk({31'h0, rerr}, 32'h1);
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
